// >>> rtl/irc_consts.svh
// Register indices, field positions and reset values of the interrupt block.
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IRC_IDX_GROUP_SOURCE_SELECT 10'h00F
`define IRC_IDX_PIN_EDGE_SELECT 10'h01F
`define IRC_IDX_INTERRUPT_ENABLE_ONE 10'h02E
`define IRC_IDX_INTERRUPT_ENABLE_TWO 10'h02F
`define IRC_IDX_FREQ_COUNTER_REQUEST 10'h03A
`define IRC_IDX_SERIAL0_REQUEST 10'h03B
`define IRC_IDX_BASIC_TIMER1_REQUEST 10'h03C
`define IRC_IDX_TIMER12_REQUEST 10'h03D
`define IRC_IDX_GROUP_REQUEST 10'h03E
`define IRC_IDX_EXT_PIN_A_REQUEST 10'h03F
`define IRC_IDX_EVENT_STATUS 10'h040
`define IRC_IDX_EVENT_MASK 10'h041

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IRC_BIT_GROUP_SOURCE 0
`define IRC_BIT_EDGE_PIN_B 1
`define IRC_BIT_EDGE_PIN_A 0
`define IRC_BIT_REQUEST_FLAG 0
`define IRC_BIT_PIN_LEVEL 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IRC_RST_CTRL4 4'h0
`define IRC_RST_SRC6 6'h00
`define IRC_RST_WORD 32'h0000_0000

`endif

// >>> rtl/irc_pkg.sv
// Types shared by the interrupt request control block.
package irc_pkg;

    // Source order; bit positions match the enable layout of both
    // enable registers read as one six-bit vector.
    typedef enum logic [2:0] {
        IRC_SRC_EXT_PIN_A = 3'h0,
        IRC_SRC_GROUP = 3'h1,
        IRC_SRC_TIMER12 = 3'h2,
        IRC_SRC_BASIC_TIMER1 = 3'h3,
        IRC_SRC_SERIAL0 = 3'h4,
        IRC_SRC_FREQ_COUNTER = 3'h5
    } irc_src_idx_t;

    // Event pulses from the on-chip peripherals.
    typedef struct packed {
        logic freq_counter;
        logic serial0;
        logic basic_timer1;
        logic timer12;
        logic timer_overflow;
    } irc_src_t;

    // Whole state of the block.
    typedef struct packed {
        logic group_source_bit;
        logic [1:0] edge_sel;
        logic [1:0] enable_one;
        logic [3:0] enable_two;
        logic [5:0] flags;
        logic [5:0] event_status;
        logic [5:0] event_mask;
        logic pin_a_prev;
        logic pin_b_prev;
        logic primed;
        logic [31:0] rdata;
        logic rerr;
    } irc_state_t;

endpackage

// >>> rtl/irc_top.sv
// Interrupt request control block with its APB register slave.
`timescale 1ns/10ps
`include "irc_consts.svh"

// What this block does
// - The group flag is set by a pin B edge when the group source bit is 0 and by timer overflow when it is 1.
// - Each pin has an edge select bit, 0 for rising and 1 for falling edge.
// - Six enable bits, one per source, 0 disables and 1 enables.
// - Enable one holds frequency counter and serial 0; enable two holds timer 1, timer 12, group and pin A.
// - A dedicated flag records a pending frequency counter request.
// - Every request flag reads 1 while pending and is readable and writable.
// - The group flag captures a pin B or timer overflow request per the group source selection.
// - Bit 3 of the group and pin A request registers shows the live pin level.
// - The overflow source is the event that sets the timer overflow flag.
module irc_top
    import irc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_stop_reset,
    input wire logic chip_enable_reset,
    input wire irc_src_t src_event,
    input wire logic ext_pin_a,
    input wire logic ext_pin_b,
    output logic [5:0] cpu_request,
    output logic irq
);

    // ------------------------------------------------------------------
    // State and decode signals
    // ------------------------------------------------------------------
    irc_state_t s_q;
    irc_state_t s_d;
    logic [9:0] idx;
    logic aligned;
    logic wr;
    logic setup;
    logic [5:0] ev;
    logic [5:0] en_all;
    logic edge_a;
    logic edge_b;
    logic soft_reset;

    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign soft_reset = clock_stop_reset | chip_enable_reset;
    assign en_all = {s_q.enable_one, s_q.enable_two};

    // ------------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------------
    // The primed bit keeps the first sample after reset from faking an
    // edge against the constant reset value of the previous levels.
    always_comb begin
        if (s_q.edge_sel[`IRC_BIT_EDGE_PIN_A]) begin
            edge_a = s_q.primed & s_q.pin_a_prev & ~ext_pin_a;
        end else begin
            edge_a = s_q.primed & ~s_q.pin_a_prev & ext_pin_a;
        end
        if (s_q.edge_sel[`IRC_BIT_EDGE_PIN_B]) begin
            edge_b = s_q.primed & s_q.pin_b_prev & ~ext_pin_b;
        end else begin
            edge_b = s_q.primed & ~s_q.pin_b_prev & ext_pin_b;
        end
    end

    // ------------------------------------------------------------------
    // Source events
    // ------------------------------------------------------------------
    always_comb begin
        ev = `IRC_RST_SRC6;
        ev[IRC_SRC_FREQ_COUNTER] = src_event.freq_counter;
        ev[IRC_SRC_SERIAL0] = src_event.serial0;
        ev[IRC_SRC_BASIC_TIMER1] = src_event.basic_timer1;
        ev[IRC_SRC_TIMER12] = src_event.timer12;
        if (s_q.group_source_bit) begin
            ev[IRC_SRC_GROUP] = src_event.timer_overflow;
        end else begin
            ev[IRC_SRC_GROUP] = edge_b;
        end
        ev[IRC_SRC_EXT_PIN_A] = edge_a;
    end

    // ------------------------------------------------------------------
    // Read data for the addressed register
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_word(input irc_state_t st,
                                              input logic [9:0] ri,
                                              input logic pa,
                                              input logic pb);
        logic [31:0] w;
        w = `IRC_RST_WORD;
        if (ri == `IRC_IDX_GROUP_SOURCE_SELECT) begin
            w[`IRC_BIT_GROUP_SOURCE] = st.group_source_bit;
        end else if (ri == `IRC_IDX_PIN_EDGE_SELECT) begin
            w[1:0] = st.edge_sel;
        end else if (ri == `IRC_IDX_INTERRUPT_ENABLE_ONE) begin
            w[1:0] = st.enable_one;
        end else if (ri == `IRC_IDX_INTERRUPT_ENABLE_TWO) begin
            w[3:0] = st.enable_two;
        end else if (ri == `IRC_IDX_FREQ_COUNTER_REQUEST) begin
            w[`IRC_BIT_REQUEST_FLAG] = st.flags[IRC_SRC_FREQ_COUNTER];
        end else if (ri == `IRC_IDX_SERIAL0_REQUEST) begin
            w[`IRC_BIT_REQUEST_FLAG] = st.flags[IRC_SRC_SERIAL0];
        end else if (ri == `IRC_IDX_BASIC_TIMER1_REQUEST) begin
            w[`IRC_BIT_REQUEST_FLAG] = st.flags[IRC_SRC_BASIC_TIMER1];
        end else if (ri == `IRC_IDX_TIMER12_REQUEST) begin
            w[`IRC_BIT_REQUEST_FLAG] = st.flags[IRC_SRC_TIMER12];
        end else if (ri == `IRC_IDX_GROUP_REQUEST) begin
            w[`IRC_BIT_PIN_LEVEL] = pb;
            w[`IRC_BIT_REQUEST_FLAG] = st.flags[IRC_SRC_GROUP];
        end else if (ri == `IRC_IDX_EXT_PIN_A_REQUEST) begin
            w[`IRC_BIT_PIN_LEVEL] = pa;
            w[`IRC_BIT_REQUEST_FLAG] = st.flags[IRC_SRC_EXT_PIN_A];
        end else if (ri == `IRC_IDX_EVENT_STATUS) begin
            w[5:0] = st.event_status;
        end else if (ri == `IRC_IDX_EVENT_MASK) begin
            w[5:0] = st.event_mask;
        end
        return w;
    endfunction

    function automatic logic is_mapped(input logic [9:0] ri);
        logic m;
        m = 1'b0;
        if (ri == `IRC_IDX_GROUP_SOURCE_SELECT ||
            ri == `IRC_IDX_PIN_EDGE_SELECT ||
            ri == `IRC_IDX_INTERRUPT_ENABLE_ONE ||
            ri == `IRC_IDX_INTERRUPT_ENABLE_TWO) begin
            m = 1'b1;
        end else if (ri >= `IRC_IDX_FREQ_COUNTER_REQUEST &&
                     ri <= `IRC_IDX_EVENT_MASK) begin
            m = 1'b1;
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic hit;
        logic [5:0] flag_wr;
        logic [5:0] flag_val;
        hit = aligned & is_mapped(idx);
        flag_wr = `IRC_RST_SRC6;
        flag_val = {6{pwdata[`IRC_BIT_REQUEST_FLAG]}};
        s_d = s_q;
        s_d.pin_a_prev = ext_pin_a;
        s_d.pin_b_prev = ext_pin_b;
        s_d.primed = 1'b1;

        // Registered read data is captured in the setup cycle.
        if (setup) begin
            s_d.rdata = hit ? read_word(s_q, idx, ext_pin_a, ext_pin_b)
                            : `IRC_RST_WORD;
            s_d.rerr = ~hit;
        end

        // Writes take effect at the access edge.
        if (wr && aligned) begin
            if (idx == `IRC_IDX_GROUP_SOURCE_SELECT) begin
                s_d.group_source_bit = pwdata[`IRC_BIT_GROUP_SOURCE];
            end else if (idx == `IRC_IDX_PIN_EDGE_SELECT) begin
                s_d.edge_sel = pwdata[1:0];
            end else if (idx == `IRC_IDX_INTERRUPT_ENABLE_ONE) begin
                s_d.enable_one = pwdata[1:0];
            end else if (idx == `IRC_IDX_INTERRUPT_ENABLE_TWO) begin
                s_d.enable_two = pwdata[3:0];
            end else if (idx == `IRC_IDX_FREQ_COUNTER_REQUEST) begin
                flag_wr[IRC_SRC_FREQ_COUNTER] = 1'b1;
            end else if (idx == `IRC_IDX_SERIAL0_REQUEST) begin
                flag_wr[IRC_SRC_SERIAL0] = 1'b1;
            end else if (idx == `IRC_IDX_BASIC_TIMER1_REQUEST) begin
                flag_wr[IRC_SRC_BASIC_TIMER1] = 1'b1;
            end else if (idx == `IRC_IDX_TIMER12_REQUEST) begin
                flag_wr[IRC_SRC_TIMER12] = 1'b1;
            end else if (idx == `IRC_IDX_GROUP_REQUEST) begin
                flag_wr[IRC_SRC_GROUP] = 1'b1;
            end else if (idx == `IRC_IDX_EXT_PIN_A_REQUEST) begin
                flag_wr[IRC_SRC_EXT_PIN_A] = 1'b1;
            end else if (idx == `IRC_IDX_EVENT_STATUS) begin
                s_d.event_status = s_q.event_status & ~pwdata[5:0];
            end else if (idx == `IRC_IDX_EVENT_MASK) begin
                s_d.event_mask = pwdata[5:0];
            end
        end

        // Hardware events win over a software clear in the same cycle.
        s_d.flags = (s_q.flags & ~flag_wr) | (flag_val & flag_wr)
                    | ev;
        s_d.event_status = s_d.event_status | ev;

        // Clock-stop and chip-enable resets clear all control bits.
        if (soft_reset) begin
            s_d.group_source_bit = 1'b0;
            s_d.edge_sel = 2'h0;
            s_d.enable_one = 2'h0;
            s_d.enable_two = `IRC_RST_CTRL4;
            s_d.flags = `IRC_RST_SRC6;
            s_d.event_status = `IRC_RST_SRC6;
            s_d.event_mask = `IRC_RST_SRC6;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_req
            assign cpu_request[gi] = s_q.flags[gi] & en_all[gi];
        end
    endgenerate

    assign irq = |(s_q.event_status & s_q.event_mask);
    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & s_q.rerr;

endmodule

// >>> tb/irc_far_model.sv
// Model of the peripheral event sources and the external pins.
`timescale 1ns/10ps
module irc_far_model
    import irc_pkg::*;
(
    input wire logic pclk,
    input wire irc_src_t fire,
    input wire logic lvl_a,
    input wire logic lvl_b,
    output irc_src_t src_event,
    output logic ext_pin_a,
    output logic ext_pin_b
);
    // Pulses and pin levels change just after the edge.
    always_ff @(posedge pclk) begin
        src_event <= fire;
        ext_pin_a <= lvl_a;
        ext_pin_b <= lvl_b;
    end
endmodule

// >>> tb/irc_tb_top.sv
// Self-checking testbench of the interrupt request control block.
`timescale 1ns/10ps
module irc_tb_top;
    import irc_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, csr = 1'h0, cer = 1'h0, la = 1'h0, lb = 1'h0;
    logic pready, pslverr, irq, se, ext_pin_a, ext_pin_b;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [5:0] cpu_request;
    irc_src_t fire = 5'h00, src_event;
    int miscompares = 0, num_checks = 0;
    logic [11:0] ra[12] = '{12'h0E8, 12'h0EC, 12'h0F0, 12'h0F4, 12'h0F8,
        12'h0FC, 12'h03C, 12'h07C, 12'h0B8, 12'h0BC, 12'h100, 12'h104};
    logic [31:0] em[4] = '{32'h1, 32'h3, 32'h3, 32'hF};
    always #5 pclk = ~pclk;
    irc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_stop_reset(csr), .chip_enable_reset(cer),
        .src_event(src_event), .ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b),
        .cpu_request(cpu_request), .irq(irq));
    irc_far_model u_far (.pclk(pclk), .fire(fire), .lvl_a(la), .lvl_b(lb),
        .src_event(src_event), .ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        d = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        xfer(1'h1, a, v);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk("prdata", e, d);
    endtask
    task automatic far(input logic [4:0] e, input logic a, input logic b);
        @(posedge pclk);
        fire <= e;
        la <= a;
        lb <= b;
        @(posedge pclk);
        fire <= 5'h00;
        repeat (3) @(posedge pclk);
    endtask
    task automatic outs(input logic [5:0] c, input logic i);
        @(posedge pclk);
        chk("cpu_request", {26'h0, c}, {26'h0, cpu_request});
        chk("irq", {31'h0, i}, {31'h0, irq});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ra[i]) rd(ra[i], 32'h0);
        xfer(1'h0, 12'h000, 32'h0);
        chk("pslverr", 32'h1, {31'h0, se});
        for (int i = 0; i < 4; i++) begin
            wr(ra[i + 6], 32'hFFFF_FFFF);
            rd(ra[i + 6], em[i]);
        end
        for (int i = 0; i < 4; i++) begin
            far(5'h10 >> i, 1'h0, 1'h0);
            outs(6'h20 >> i, 1'h0);
            rd(ra[i], 32'h1);
            wr(ra[i], 32'h0);
            rd(ra[i], 32'h0);
            wr(ra[i], 32'h1);
            rd(ra[i], 32'h1);
            wr(ra[i], 32'h0);
        end
        wr(12'h07C, 32'h0);
        far(5'h00, 1'h0, 1'h1);
        rd(12'h0F8, 32'h8);
        far(5'h01, 1'h0, 1'h1);
        rd(12'h0F8, 32'h9);
        outs(6'h02, 1'h0);
        wr(12'h0F8, 32'h0);
        wr(12'h03C, 32'h0);
        far(5'h01, 1'h0, 1'h1);
        rd(12'h0F8, 32'h8);
        far(5'h00, 1'h0, 1'h0);
        far(5'h00, 1'h0, 1'h1);
        rd(12'h0F8, 32'h9);
        wr(12'h0F8, 32'h0);
        far(5'h00, 1'h1, 1'h1);
        rd(12'h0FC, 32'h9);
        wr(12'h0FC, 32'h0);
        wr(12'h07C, 32'h1);
        far(5'h00, 1'h0, 1'h1);
        rd(12'h0FC, 32'h1);
        wr(12'h0BC, 32'h0);
        outs(6'h00, 1'h0);
        rd(12'h100, 32'h3F);
        wr(12'h104, 32'h20);
        outs(6'h00, 1'h1);
        wr(12'h100, 32'h20);
        rd(12'h100, 32'h1F);
        outs(6'h00, 1'h0);
        for (int k = 0; k < 2; k++) begin
            wr(12'h0B8, 32'h3);
            @(posedge pclk);
            {cer, csr} <= 2'h1 << k;
            @(posedge pclk);
            {cer, csr} <= 2'h0;
            rd(12'h0B8, 32'h0);
            rd(12'h100, 32'h0);
        end
        print_verdict();
    end
endmodule

// >>> tb/irc_top_asserts.sv
// Port checker for the interrupt request control block.
`timescale 1ns/10ps
module irc_top_asserts
    import irc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clock_stop_reset,
    input wire logic chip_enable_reset,
    input wire irc_src_t src_event,
    input wire logic ext_pin_a,
    input wire logic ext_pin_b,
    input wire logic [5:0] cpu_request,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    wire apb_wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_pin_a_read;
        psel && !penable && !pwrite && paddr == 12'h0FC;
    endsequence
    sequence s_pin_a_edge;
        $past(ext_pin_a) != $past(ext_pin_a, 2);
    endsequence
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");
    a_unmapped_err: assert property (psel && penable && paddr == 12'h000
        |-> pslverr) else $error("unmapped access not refused");
    a_stop_clears: assert property (clock_stop_reset |=>
        cpu_request == 6'h00 && !irq) else $error("stop reset kept state");
    a_ce_clears: assert property (chip_enable_reset |=>
        cpu_request == 6'h00 && !irq) else $error("ce reset kept state");
    a_freq_cause: assert property ($rose(cpu_request[5]) |->
        $past(apb_wr) || $past(src_event.freq_counter))
        else $error("freq request without cause");
    a_pina_cause: assert property ($rose(cpu_request[0]) |->
        $past(apb_wr) or s_pin_a_edge) else $error("pin request no edge");
    a_grp_cause: assert property ($rose(cpu_request[1]) |->
        $past(apb_wr) || $past(src_event.timer_overflow)
        || $past(ext_pin_b) != $past(ext_pin_b, 2))
        else $error("group request without cause");
    a_fall_cause: assert property (|($past(cpu_request) & ~cpu_request)
        |-> $past(apb_wr) || $past(clock_stop_reset)
        || $past(chip_enable_reset)) else $error("request fell alone");
    a_pin_level: assert property (s_pin_a_read |=>
        prdata[3] == $past(ext_pin_a) && prdata[31:4] == 28'h0)
        else $error("pin level read wrong");
endmodule
bind irc_top irc_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_stop_reset(clock_stop_reset),
    .chip_enable_reset(chip_enable_reset), .src_event(src_event),
    .ext_pin_a(ext_pin_a), .ext_pin_b(ext_pin_b),
    .cpu_request(cpu_request), .irq(irq));
